// ==== afu_core.sv ====
// Audio frame pulse, ten-field marker and four user timing pulses.
// Assumes sync leading-edge pulses from a timing generator on CLK_I.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Audio pulse spans line 1 of n'th frame
// - Period n from standard and rate selects
// - Fractional rate with 48k gives n of five
// - Reference marker edge restarts audio sequence
// - Software may ignore the reference marker for the audio sequence
// - Sequence register write with bit 0 set restarts audio sequence
// - Without reference the counter free-runs
// - Polarity bit inverts the audio pulse
// - Four user pulses, four registers each
// - Start and stop in pixels and lines
// - Positions count from sync leading edges
// - User pulses merge by AND, OR, XOR
// - Ten-field marker high one line
module afu_core
    import afu_pkg::*;
#(
    parameter logic [63:0] FRAC_STD_MASK = 64'h0000_0000_0000_000f
)
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire afu_apb_req_t APB_REQ_I,
    output afu_apb_rsp_t APB_RSP_O,
    input wire afu_vtim_t VID_TIM_I,
    input wire logic [5:0] VIDEO_STANDARD_SELECT_I,
    input wire logic [2:0] AUDIO_RATE_SELECT_I,
    input wire logic TEN_FIELD_REF_I,
    output logic AUDIO_FRAME_PULSE_O,
    output logic TEN_FIELD_MARKER_O,
    output logic [USERS-1:0] USER_PULSE_O,
    output logic USER_COMBINED_O
);
    afu_state_t q;
    afu_state_t d;
    logic [USERS-1:0] usr_act;
    logic [USERS-1:0] usr_mask;
    logic [5:0] sel_std;
    logic [2:0] sel_rate;
    logic frac;
    logic ref_edge;
    logic rrst;
    logic hrst;
    logic [9:0] idx;
    logic [9:0] ut_off;
    logic access;
    logic done;
    logic hit;
    logic [15:0] rd;
    logic [6:0] n_sel;
    afu_cmb_t fn;

    // window per user, counted from sync edges
    for (genvar g = 0; g < USERS; g++)
    begin : g_usr
        assign usr_act[g] = (q.hcnt >= q.utim[4*g]) && (q.hcnt < q.utim[4*g+1])
            && (q.vcnt >= q.utim[4*g+2]) && (q.vcnt < q.utim[4*g+3]);
    end

    assign usr_mask = q.cmb[CMB_MASK_LSB +: USERS];
    assign fn = afu_cmb_t'(q.cmb[CMB_FN_LSB +: 2]);
    assign ref_edge = q.ref_sync[1] & ~q.ref_sync[2];
    // host fields override the select pins
    assign sel_std = q.acw[ACW_HOST_SEL] ? q.acw[ACW_STD_LSB +: 6] : q.std_sync[1];
    assign sel_rate = q.acw[ACW_HOST_SEL] ? q.acw[ACW_RATE_LSB +: 3] : q.rate_sync[1];
    assign frac = FRAC_STD_MASK[sel_std];
    assign idx = APB_REQ_I.paddr[ADDR_W-1:2];
    assign ut_off = idx - IDX_UTB;
    assign access = APB_REQ_I.psel & APB_REQ_I.penable;
    assign done = access & q.rsp.pready;
    assign rrst = ref_edge & ~q.acw[ACW_NO_REF];
    // host restart on sequence register write with bit 0 set
    assign hrst = done & APB_REQ_I.pwrite & (idx == IDX_FSC)
        & APB_REQ_I.pwdata[FSC_AFP_RST];

    always_comb
    begin
        n_sel = N_PLAIN;
        if (frac)
        begin
            case (sel_rate)
                RATE_48K: n_sel = N_48K;
                RATE_96K: n_sel = N_48K;
                RATE_44K1: n_sel = N_44K1;
                RATE_32K: n_sel = N_32K;
                default: n_sel = N_PLAIN;
            endcase
        end
    end

    always_comb
    begin
        hit = 1'b1;
        rd = 16'h0000;
        if (APB_REQ_I.paddr[1:0] != 2'h0)
            hit = 1'b0;
        else if (idx == IDX_FSC)
            rd = q.fsc;
        else if (idx == IDX_ACW)
            rd = q.acw;
        else if (idx == IDX_POL)
            rd = q.pol;
        else if (idx == IDX_CMB)
            rd = q.cmb;
        else if (ut_off < UT_COUNT)
            rd = q.utim[ut_off[3:0]];
        else
            hit = 1'b0;
    end

    always_comb
    begin
        d = q;
        // Pins cross in through two stages
        d.std_sync[0] = VIDEO_STANDARD_SELECT_I;
        d.std_sync[1] = q.std_sync[0];
        d.rate_sync[0] = AUDIO_RATE_SELECT_I;
        d.rate_sync[1] = q.rate_sync[0];
        d.ref_sync = {q.ref_sync[1:0], TEN_FIELD_REF_I};
        d.n = n_sel;

        // One wait state keeps decode off the answer path
        d.rsp.pready = access & ~q.rsp.pready;
        d.rsp.pslverr = d.rsp.pready & ~hit;
        d.rsp.prdata = (d.rsp.pready && hit && !APB_REQ_I.pwrite) ? {16'h0000, rd} : 32'h0;
        if (done && APB_REQ_I.pwrite && hit)
        begin
            if (idx == IDX_FSC)
                d.fsc = APB_REQ_I.pwdata[15:0];
            else if (idx == IDX_ACW)
                d.acw = APB_REQ_I.pwdata[15:0];
            else if (idx == IDX_POL)
                d.pol = APB_REQ_I.pwdata[15:0];
            else if (idx == IDX_CMB)
                d.cmb = APB_REQ_I.pwdata[15:0];
            else
                d.utim[ut_off[3:0]] = APB_REQ_I.pwdata[15:0];
        end

        d.hcnt = VID_TIM_I.hs_lead ? 16'h0000 : q.hcnt + 16'h0001;
        if (VID_TIM_I.vs_lead)
            d.vcnt = 16'h0000;
        else if (VID_TIM_I.hs_lead)
            d.vcnt = q.vcnt + 16'h0001;

        // divide by n; restart lands on zero next frame
        if (hrst || rrst)
            d.afc = q.n - 7'h01;
        else if (VID_TIM_I.frame_start)
            d.afc = (q.afc >= q.n - 7'h01) ? 7'h00 : q.afc + 7'h01;
        // raised at line 1, dropped at next line
        if (VID_TIM_I.frame_start)
            d.afp = (d.afc == 7'h00);
        else if (VID_TIM_I.hs_lead)
            d.afp = 1'b0;

        // five-frame cadence follows the reference always
        if (ref_edge)
            d.tfc = TF_LAST;
        else if (VID_TIM_I.frame_start)
            d.tfc = (q.tfc == TF_LAST) ? 3'h0 : q.tfc + 3'h1;
        if (VID_TIM_I.frame_start)
            d.tfm = frac & (d.tfc == 3'h0);
        else if (VID_TIM_I.hs_lead)
            d.tfm = 1'b0;

        d.afp_o = d.afp ^ d.pol[POL_AFP];
        d.tfm_o = d.tfm ^ d.pol[POL_TFM];
        d.usr_o = usr_act ^ q.pol[POL_USR_LSB +: USERS];
        case (fn)
            CMB_NONE: d.cmb_o = 1'b0;
            CMB_AND: d.cmb_o = (usr_mask != 4'h0) && ((usr_act | ~usr_mask) == 4'hf);
            CMB_OR: d.cmb_o = |(usr_act & usr_mask);
            CMB_XOR: d.cmb_o = ^(usr_act & usr_mask);
            default: d.cmb_o = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            q <= ST_RST;
        else
            q <= d;
    end

    assign APB_RSP_O = q.rsp;
    assign AUDIO_FRAME_PULSE_O = q.afp_o;
    assign TEN_FIELD_MARKER_O = q.tfm_o;
    assign USER_PULSE_O = q.usr_o;
    assign USER_COMBINED_O = q.cmb_o;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);

    AST_AFP_START: assert property ($rose(q.afp) |-> $past(VID_TIM_I.frame_start))
        else $error("Audio pulse rose off line 1");
    AST_AFP_HOLD: assert property (q.afp && !VID_TIM_I.hs_lead && !VID_TIM_I.frame_start
        |=> q.afp)
        else $error("Audio pulse dropped mid-line");
    // Reset edge leaves the period at zero for a cycle
    AST_N_PLAIN: assert property (!SRST_I && !frac |=> q.n == N_PLAIN)
        else $error("Integer rate standard period not one");
    AST_N_FIVE: assert property (!SRST_I && frac && sel_rate == RATE_48K
        |=> q.n == N_48K)
        else $error("Fractional 48k period not five");
    AST_REF_RST: assert property (rrst |=> q.afc == $past(q.n) - 7'h01)
        else $error("Reference did not restart sequence");
    AST_REF_OFF: assert property (ref_edge && q.acw[ACW_NO_REF] && !hrst
        && !VID_TIM_I.frame_start |=> $stable(q.afc))
        else $error("Disabled reference still moved counter");
    AST_HOST_RST: assert property (hrst |=> q.afc == $past(q.n) - 7'h01)
        else $error("Host write did not restart sequence");
    AST_FREE_RUN: assert property (VID_TIM_I.frame_start && !hrst && !rrst
        && q.afc < q.n - 7'h01 |=> q.afc == $past(q.afc) + 7'h01)
        else $error("Counter did not advance");
    AST_WRAP: assert property (VID_TIM_I.frame_start && !hrst && !rrst
        && q.afc == q.n - 7'h01 |=> q.afp && q.afc == 7'h00)
        else $error("Wrap to zero gave no pulse");
    AST_POL: assert property (AUDIO_FRAME_PULSE_O == (q.afp ^ q.pol[POL_AFP]))
        else $error("Audio pulse polarity wrong");
    AST_HZERO: assert property (VID_TIM_I.hs_lead ##1 !VID_TIM_I.hs_lead
        |=> q.hcnt == 16'h0001)
        else $error("Pixel count not from sync edge");
    AST_USR0: assert property (usr_act[0] ##1 $stable(q.pol)
        |-> USER_PULSE_O[0] != q.pol[POL_USR_LSB])
        else $error("User pulse zero not active in window");
    AST_XOR: assert property (fn == CMB_XOR && ^(usr_act & usr_mask)
        |=> USER_COMBINED_O)
        else $error("XOR composite wrong");
    AST_TFM: assert property ($rose(q.tfm)
        |-> $past(VID_TIM_I.frame_start) && $past(frac))
        else $error("Ten-field marker off line 1");

    // Bus answer: one wait state, one-cycle strobes
    AST_READY_ONCE: assert property (q.rsp.pready |=> !q.rsp.pready)
        else $error("Ready held past one cycle");
    AST_READY_WAIT: assert property (access && !q.rsp.pready |=> q.rsp.pready)
        else $error("Access got no ready after one wait");
    AST_ERR_READY: assert property (q.rsp.pslverr |-> q.rsp.pready)
        else $error("Error raised without ready");
    AST_RDATA_IDLE: assert property (!q.rsp.pready |-> q.rsp.prdata == 32'h0)
        else $error("Read data not zero between answers");
    AST_RDATA_HIGH: assert property (q.rsp.prdata[31:16] == 16'h0000)
        else $error("Upper read data bits not zero");
    AST_WR_ACW: assert property (done && APB_REQ_I.pwrite && idx == IDX_ACW
        && APB_REQ_I.paddr[1:0] == 2'h0
        |=> q.acw == $past(APB_REQ_I.pwdata[15:0]))
        else $error("Audio config write lost");
    AST_WR_POL: assert property (done && APB_REQ_I.pwrite && idx == IDX_POL
        && APB_REQ_I.paddr[1:0] == 2'h0
        |=> q.pol == $past(APB_REQ_I.pwdata[15:0]))
        else $error("Polarity write lost");
    // Line-level shape of the audio pulse and marker
    AST_AFP_FALL: assert property (q.afp && VID_TIM_I.hs_lead
        && !VID_TIM_I.frame_start |=> !q.afp)
        else $error("Audio pulse outlived its line");
    AST_AFP_ZERO: assert property ($rose(q.afp) |-> q.afc == 7'h00)
        else $error("Audio pulse away from count zero");
    AST_N_44K: assert property (!SRST_I && frac && sel_rate == RATE_44K1
        |=> q.n == N_44K1)
        else $error("Fractional 44.1k period wrong");
    AST_TFM_HOLD: assert property (q.tfm && !VID_TIM_I.hs_lead
        && !VID_TIM_I.frame_start |=> q.tfm)
        else $error("Ten-field marker dropped mid-line");
    AST_TFM_FALL: assert property (q.tfm && VID_TIM_I.hs_lead
        && !VID_TIM_I.frame_start |=> !q.tfm)
        else $error("Ten-field marker outlived its line");
    AST_TFM_INT: assert property (VID_TIM_I.frame_start && !frac |=> !q.tfm)
        else $error("Ten-field marker on whole-rate standard");
    AST_TF_REF: assert property (ref_edge |=> q.tfc == TF_LAST)
        else $error("Reference did not align marker cadence");
    // Counters restart on sync edges and step by one
    AST_HSTEP: assert property (!SRST_I && !VID_TIM_I.hs_lead
        |=> q.hcnt == $past(q.hcnt) + 16'h0001)
        else $error("Pixel count did not step");
    AST_VZERO: assert property (VID_TIM_I.vs_lead |=> q.vcnt == 16'h0000)
        else $error("Line count not cleared at vertical sync");
    AST_VSTEP: assert property (VID_TIM_I.hs_lead && !VID_TIM_I.vs_lead
        |=> q.vcnt == $past(q.vcnt) + 16'h0001)
        else $error("Line count did not step");
    // Idle user outputs rest at their polarity level
    AST_USR1_OFF: assert property (!usr_act[1] ##1 $stable(q.pol)
        |-> USER_PULSE_O[1] == q.pol[POL_USR_LSB + 1])
        else $error("User pulse one active outside window");
    AST_AND: assert property (fn == CMB_AND && usr_mask != 4'h0
        && (usr_act | ~usr_mask) == 4'hf |=> USER_COMBINED_O)
        else $error("AND composite wrong");
    AST_AND_EMPTY: assert property (fn == CMB_AND && usr_mask == 4'h0
        |=> !USER_COMBINED_O)
        else $error("AND of empty mask not low");
    AST_OR: assert property (fn == CMB_OR && |(usr_act & usr_mask)
        |=> USER_COMBINED_O)
        else $error("OR composite wrong");
    AST_CMB_NONE: assert property (fn == CMB_NONE |=> !USER_COMBINED_O)
        else $error("Composite high with no function");
endmodule : afu_core

`default_nettype wire

// ==== afu_pkg.sv ====
// Constants, carriers and state for the audio frame and user pulse block.
// Assumes a video timing generator on the same pixel clock.
package afu_pkg;
    localparam int ADDR_W = 12;
    localparam int USERS = 4;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FSC = 10'h01a;
    localparam logic [9:0] IDX_ACW = 10'h031;
    localparam logic [9:0] IDX_POL = 10'h056;
    localparam logic [9:0] IDX_UTB = 10'h057;
    localparam logic [9:0] IDX_CMB = 10'h067;
    localparam logic [9:0] UT_COUNT = 10'h010;
    localparam logic [15:0] REG_RST = 16'h0000;
    // Field positions
    localparam int FSC_AFP_RST = 0;
    localparam int ACW_NO_REF = 0;
    localparam int ACW_HOST_SEL = 1;
    localparam int ACW_RATE_LSB = 2;
    localparam int ACW_STD_LSB = 5;
    localparam int POL_AFP = 0;
    localparam int POL_TFM = 1;
    localparam int POL_USR_LSB = 2;
    localparam int CMB_FN_LSB = 0;
    localparam int CMB_MASK_LSB = 2;
    // Audio rate codes and frame periods
    localparam logic [2:0] RATE_48K = 3'h0;
    localparam logic [2:0] RATE_44K1 = 3'h1;
    localparam logic [2:0] RATE_32K = 3'h2;
    localparam logic [2:0] RATE_96K = 3'h3;
    localparam logic [6:0] N_48K = 7'h05;
    localparam logic [6:0] N_44K1 = 7'h64;
    localparam logic [6:0] N_32K = 7'h0f;
    localparam logic [6:0] N_PLAIN = 7'h01;
    localparam logic [2:0] TF_LAST = 3'h4;

    typedef enum logic [1:0] {CMB_NONE, CMB_AND, CMB_OR, CMB_XOR} afu_cmb_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } afu_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } afu_apb_rsp_t;

    typedef struct packed {
        logic hs_lead;
        logic vs_lead;
        logic frame_start;
    } afu_vtim_t;

    typedef struct packed {
        logic [1:0][5:0] std_sync;
        logic [1:0][2:0] rate_sync;
        logic [2:0] ref_sync;
        logic [15:0] fsc;
        logic [15:0] acw;
        logic [15:0] pol;
        logic [15:0] cmb;
        logic [15:0][15:0] utim;
        logic [6:0] n;
        logic [6:0] afc;
        logic [2:0] tfc;
        logic [15:0] hcnt;
        logic [15:0] vcnt;
        logic afp;
        logic tfm;
        logic afp_o;
        logic tfm_o;
        logic [USERS-1:0] usr_o;
        logic cmb_o;
        afu_apb_rsp_t rsp;
    } afu_state_t;

    localparam afu_state_t ST_RST = '0;
endpackage : afu_pkg

// ==== afu_vtim_gen.sv ====
// Small video timing source driving the sync inputs.
// Assumes the pixel clock and synchronous reset of the block.
`timescale 1ns/1ps
`default_nettype none
module afu_vtim_gen
    import afu_pkg::*;
#(
    parameter int H_TOTAL = 20,
    parameter int V_TOTAL = 6
)
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    output afu_vtim_t VID_TIM_O
);
    int h_reg;
    int v_reg;
    // Short lines and frames keep the run brief
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            h_reg <= 0;
            v_reg <= 0;
            VID_TIM_O <= '0;
        end
        else
        begin
            h_reg <= (h_reg + 1) % H_TOTAL;
            if (h_reg == H_TOTAL - 1)
                v_reg <= (v_reg + 1) % V_TOTAL;
            VID_TIM_O.hs_lead <= (h_reg == 0);
            VID_TIM_O.vs_lead <= (h_reg == 0) && (v_reg == 0);
            VID_TIM_O.frame_start <= (h_reg == 0) && (v_reg == 0);
        end
    end
endmodule : afu_vtim_gen
`default_nettype wire

// ==== audio_frame_sync_user_timing_tb.sv ====
// Self-checking bench for the audio frame and user pulse block.
// Assumes the timing source model drives the sync inputs.
`timescale 1ns/1ps
`default_nettype none
module audio_frame_sync_user_timing_tb
    import afu_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    afu_apb_req_t req = '0;
    afu_apb_rsp_t rsp;
    afu_vtim_t vt;
    logic [5:0] std = 6'h00;
    logic [2:0] rate = 3'h0;
    logic tref = 1'b0;
    logic afp;
    logic tfm;
    logic cmb;
    logic [3:0] usr;
    logic [31:0] seed = 32'h00013fe3;
    logic [31:0] rd;
    logic [31:0] v;
    logic er;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int afc = 0;
    int nn = N_48K;
    int hs;
    int hw;
    int cnt;
    int cc;
    int cu;

    afu_vtim_gen tgen (.CLK_I(clk), .SRST_I(rst), .VID_TIM_O(vt));
    afu_core uut (.CLK_I(clk), .SRST_I(rst), .APB_REQ_I(req), .APB_RSP_O(rsp),
        .VID_TIM_I(vt), .VIDEO_STANDARD_SELECT_I(std), .AUDIO_RATE_SELECT_I(rate),
        .TEN_FIELD_REF_I(tref), .AUDIO_FRAME_PULSE_O(afp), .TEN_FIELD_MARKER_O(tfm),
        .USER_PULSE_O(usr), .USER_COMBINED_O(cmb));

    always #5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Extra idle edge keeps back-to-back calls from double driving
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Model advances mod n at each frame start
    task automatic frames(input int k, input logic pol, input logic tf);
        repeat (k)
        begin
            do @(posedge clk); while (vt.frame_start !== 1'b1);
            afc = (afc + 1) % nn;
            @(posedge clk);
            chk("afp", 32'((afc == 0) ^ pol), 32'(afp));
            if (tf)
                chk("tfm", 32'(afc == 0), 32'(tfm));
            repeat (20) @(posedge clk);
            chk("afp_end", 32'(pol), 32'(afp));
        end
    endtask : frames

    task automatic ref_pulse();
        tref <= 1'b1;
        repeat (4) @(posedge clk);
        tref <= 1'b0;
    endtask : ref_pulse

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        do @(posedge clk); while (vt.frame_start !== 1'b1);
        ref_pulse();
        afc = 4;
        frames(6, 1'b0, 1'b1);
        apb(1'b1, 12'h0c4, 32'h1);
        do @(posedge clk); while (vt.frame_start !== 1'b1);
        apb(1'b1, 12'h068, 32'h1);
        afc = 4;
        frames(2, 1'b0, 1'b0);
        // Ignored reference must not move the phase
        ref_pulse();
        frames(5, 1'b0, 1'b0);
        v = rnd() | 32'h1;
        apb(1'b1, 12'h158, v);
        apb(1'b0, 12'h158, 32'h0);
        chk("pol_rd", {16'h0, v[15:0]}, rd);
        chk("usr_pol", 32'(v[5:2]), 32'(usr));
        frames(2, 1'b1, 1'b0);
        apb(1'b0, 12'h3fc, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        apb(1'b1, 12'h158, 32'h0);
        hs = rnd() % 10;
        hw = 1 + rnd() % 8;
        apb(1'b1, 12'h15c, 32'(hs));
        apb(1'b1, 12'h160, 32'(hs + hw));
        apb(1'b1, 12'h164, 32'h1);
        apb(1'b1, 12'h168, 32'h3);
        for (int f = 1; f < 4; f++)
        begin
            apb(1'b1, 12'h19c, 32'(4 + f));
            repeat (240) @(posedge clk);
            cnt = 0;
            cc = 0;
            cu = 0;
            repeat (120)
            begin
                @(posedge clk);
                cnt += (usr[0] !== 1'b0);
                cc += (cmb !== 1'b0);
                cu += (usr[3:1] !== 3'h0);
            end
            chk("usr0", 32'(2 * hw), 32'(cnt));
            chk("cmb", 32'(2 * hw), 32'(cc));
            chk("usr_idle", 32'h0, 32'(cu));
        end
        // Whole-rate standard on the pins: period one, no marker
        std <= 6'(4 + rnd() % 60);
        nn = 1;
        repeat (4) @(posedge clk);
        frames(2, 1'b0, 1'b0);
        chk("tfm_int", 32'h0, 32'(tfm));
        tally_and_finish();
    end
endmodule : audio_frame_sync_user_timing_tb
`default_nettype wire
